//--- ddrsm_pkg.sv
`default_nettype none

package ddrsm_pkg;

  // ****************************************
  // Organisations and defaults
  // ****************************************
  localparam int ORG_X8     = 8;
  localparam int ORG_X9     = 9;
  localparam int ORG_X18    = 18;
  localparam int ORG_X36    = 36;
  localparam int ORG_DEF    = ORG_X18;
  localparam int ADDR_W_DEF = 19;
  localparam int BUF_DEPTH  = 2;

  // ****************************************
  // Start-up sequence
  // ****************************************
  localparam logic [1:0] BOOT_RST   = 2'h0;
  localparam logic [1:0] BOOT_STRAP = 2'h2;
  localparam logic [1:0] BOOT_DONE  = 2'h3;

  // Number of write lanes for an organisation
  function automatic int lane_cnt(input int org);
    case (org)
      ORG_X8:  return 2;
      ORG_X9:  return 1;
      ORG_X18: return 2;
      default: return 4;
    endcase
  endfunction : lane_cnt

endpackage : ddrsm_pkg

`default_nettype wire

//--- ddrsm_lane_ram.sv
`timescale 1ns/10ps
`default_nettype none

module ddrsm_lane_ram #(
  parameter int AW = 20,
  parameter int NL = 2,
  parameter int LW = 9
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [NL*LW-1:0] wr_data,
  input  wire logic [NL-1:0]    wr_lane_en,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output var  logic [NL*LW-1:0] rd_data
);

  logic [NL*LW-1:0] mem [2**AW];

  // ****************************************
  // Lane merge: only enabled lanes change
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      for (int l = 0; l < NL; l++) begin
        if (wr_lane_en[l]) begin
          mem[wr_addr][l*LW +: LW] <= wr_data[l*LW +: LW];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : ddrsm_lane_ram

`default_nettype wire

//--- ddrsm_skid_buf.sv
`timescale 1ns/10ps
`default_nettype none

module ddrsm_skid_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output var  logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output var  logic         out_valid,
  input  wire logic         out_ready,
  output var  logic [W-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] slot;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
  } ddrsm_buf_t;

  ddrsm_buf_t buf_reg;
  ddrsm_buf_t buf_next;
  logic       push;
  logic       pop;

  assign in_ready  = (buf_reg.cnt != CW'(DEPTH));
  assign out_valid = (buf_reg.cnt != '0);
  assign out_data  = buf_reg.slot[buf_reg.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    buf_next = buf_reg;
    if (push) begin
      buf_next.slot[buf_reg.wp] = in_data;
      buf_next.wp = (buf_reg.wp == PW'(DEPTH - 1)) ? '0
                    : buf_reg.wp + PW'(1);
    end
    if (pop) begin
      buf_next.rp = (buf_reg.rp == PW'(DEPTH - 1)) ? '0
                    : buf_reg.rp + PW'(1);
    end
    if (push & ~pop) begin
      buf_next.cnt = buf_reg.cnt + CW'(1);
    end else if (pop & ~push) begin
      buf_next.cnt = buf_reg.cnt - CW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      buf_reg <= '0;
    end else begin
      buf_reg <= buf_next;
    end
  end

endmodule : ddrsm_skid_buf

`default_nettype wire

//--- ddrsm_write_path.sv
`timescale 1ns/10ps
`default_nettype none

module ddrsm_write_path #(
  parameter int ORG    = ddrsm_pkg::ORG_DEF,
  parameter int ADDR_W = ddrsm_pkg::ADDR_W_DEF
) (
  input  wire logic                                 clk_sys,
  input  wire logic                                 rst_n,
  input  wire logic                                 k_clk,
  input  wire logic                                 k_clk_n,
  input  wire logic                                 c_clk,
  input  wire logic                                 c_clk_n,
  input  wire logic                                 load_strobe_n,
  input  wire logic                                 rw_n,
  input  wire logic [ADDR_W-1:0]                    addr,
  input  wire logic [ORG-1:0]                       d_in,
  input  wire logic [ddrsm_pkg::lane_cnt(ORG)-1:0]  lane_write_mask_n,
  output var  logic [ORG-1:0]                       q_out,
  output var  logic                                 q_oe,
  output var  logic                                 wr_ready,
  output var  logic                                 single_clk_mode
);

  import ddrsm_pkg::*;

  localparam int NL = lane_cnt(ORG);
  localparam int PW = 6 + ADDR_W + ORG + NL;
  localparam int MW = ADDR_W + 1;
  localparam int BW = MW + ORG + NL;

  typedef enum logic [1:0] {OUT_IDLE, OUT_W0, OUT_W1} ddrsm_out_t;

  typedef struct packed {
    logic [PW-1:0]     s1;
    logic [PW-1:0]     s2;
    logic [3:0]        ck;
    logic [1:0]        boot;
    logic              single;
    logic              wr_pend;
    logic [ADDR_W-1:0] wa;
    logic              neg_pend;
    logic [ADDR_W-1:0] wa_hi;
    logic              push_v;
    logic [BW-1:0]     push_w;
    logic              rd_pend;
    logic [ADDR_W-1:0] ra;
    logic [1:0]        fetch;
    logic [ADDR_W-1:0] fa;
    logic [1:0]        cap;
    logic [ORG-1:0]    q0;
    logic [ORG-1:0]    q1;
    ddrsm_out_t        stage;
    logic [ORG-1:0]    q;
    logic              oe;
    logic              rdy;
  } ddrsm_main_t;

  ddrsm_main_t       r_reg;
  ddrsm_main_t       r_next;

  logic              kp, kn, cp, cn, ld_n_s, rw_s;
  logic [ADDR_W-1:0] addr_s;
  logic [ORG-1:0]    d_s;
  logic [NL-1:0]     m_s;
  logic              run;
  logic              k_rise, kn_rise, out_pos, out_neg;
  logic              buf_in_rdy;
  logic              b_v;
  logic [BW-1:0]     b_w;
  logic              mem_re;
  logic              mem_we;
  logic [ORG-1:0]    mem_rd;

  // ****************************************
  // Synchronised pins and edge detection
  // ****************************************
  assign {kp, kn, cp, cn, ld_n_s, rw_s, addr_s, d_s, m_s} = r_reg.s2;

  assign run     = (r_reg.boot == BOOT_DONE);
  assign k_rise  = kp & ~r_reg.ck[3];
  assign kn_rise = kn & ~r_reg.ck[2];
  assign out_pos = r_reg.single ? k_rise : (cp & ~r_reg.ck[1]);
  assign out_neg = r_reg.single ? kn_rise : (cn & ~r_reg.ck[0]);

  assign mem_re  = (r_reg.fetch != 2'h0);
  assign mem_we  = b_v & ~mem_re;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    r_next    = r_reg;
    r_next.s1 = {k_clk, k_clk_n, c_clk, c_clk_n, load_strobe_n, rw_n,
                 addr, d_in, lane_write_mask_n};
    r_next.s2 = r_reg.s1;
    r_next.ck = {kp, kn, cp, cn};
    r_next.rdy = buf_in_rdy;
    if (!run) begin
      r_next.boot = r_reg.boot + 2'h1;
    end
    if (r_reg.boot == BOOT_STRAP) begin
      r_next.single = cp & cn;
    end
    if (buf_in_rdy) begin
      r_next.push_v = 1'b0;
    end

    // Word capture for the first data half and new commands
    if (run & k_rise) begin
      if (r_reg.wr_pend & ~(&m_s)) begin
        r_next.push_v = 1'b1;
        r_next.push_w = {r_reg.wa, 1'b0, d_s, ~m_s};
      end
      r_next.neg_pend = r_reg.wr_pend;
      r_next.wa_hi    = r_reg.wa;
      r_next.wr_pend  = ~ld_n_s & ~rw_s;
      r_next.wa       = addr_s;
      r_next.rd_pend  = ~ld_n_s & rw_s;
      r_next.ra       = addr_s;
    end

    // Second data half on the negative clock
    if (run & kn_rise & r_reg.neg_pend) begin
      r_next.neg_pend = 1'b0;
      if (~(&m_s)) begin
        r_next.push_v = 1'b1;
        r_next.push_w = {r_reg.wa_hi, 1'b1, d_s, ~m_s};
      end
    end

    // Read fetch: two array reads, word 0 then word 1
    r_next.cap = {r_reg.fetch == 2'h1, r_reg.fetch == 2'h2};
    if (mem_re) begin
      r_next.fetch = r_reg.fetch - 2'h1;
    end
    if (r_reg.cap[0]) begin
      r_next.q0 = mem_rd;
    end
    if (r_reg.cap[1]) begin
      r_next.q1 = mem_rd;
    end

    // Output sequencing on the output clock pair, or on the input clock pair in single clock mode
    if (run & out_neg & (r_reg.stage == OUT_W0)) begin
      r_next.q     = r_reg.q0;
      r_next.oe    = 1'b1;
      r_next.stage = OUT_W1;
    end
    if (run & out_pos) begin
      if (r_reg.stage == OUT_W1) begin
        r_next.q     = r_reg.q1;
        r_next.stage = OUT_IDLE;
      end else if (r_reg.stage == OUT_IDLE) begin
        r_next.oe = 1'b0;
      end
    end
    if (run & k_rise & r_reg.rd_pend) begin
      r_next.fetch = 2'h2;
      r_next.fa    = r_reg.ra;
      r_next.stage = OUT_W0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_out           = r_reg.q;
  assign q_oe            = r_reg.oe;
  assign wr_ready        = r_reg.rdy;
  assign single_clk_mode = r_reg.single;

  // ****************************************
  // Write buffer and array
  // ****************************************
  ddrsm_skid_buf #(
    .W     (BW),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (r_reg.push_v),
    .in_ready  (buf_in_rdy),
    .in_data   (r_reg.push_w),
    .out_valid (b_v),
    .out_ready (~mem_re),
    .out_data  (b_w)
  );

  ddrsm_lane_ram #(
    .AW (MW),
    .NL (NL),
    .LW (ORG / NL)
  ) u_ram (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .wr_en      (mem_we),
    .wr_addr    (b_w[BW-1 -: MW]),
    .wr_data    (b_w[NL +: ORG]),
    .wr_lane_en (b_w[NL-1:0]),
    .rd_en      (mem_re),
    .rd_addr    ({r_reg.fa, r_reg.fetch == 2'h1}),
    .rd_data    (mem_rd)
  );

  // ****************************************
  // Assertions
  // ****************************************
  property p_lane_gate;
    @(posedge clk_sys) disable iff (!rst_n)
    (run && k_rise && r_reg.wr_pend && !(&m_s))
    |=> (r_reg.push_v && r_reg.push_w[NL-1:0] == ~$past(m_s)
         && r_reg.push_w[NL +: ORG] == $past(d_s));
  endproperty
  a_lane_gate: assert property (p_lane_gate)
    else $error("lane enables differ from sampled selects");

  property p_all_off;
    @(posedge clk_sys) disable iff (!rst_n)
    (run && &m_s && !r_reg.push_v
     && ((k_rise && r_reg.wr_pend) || (kn_rise && r_reg.neg_pend)))
    |=> !r_reg.push_v;
  endproperty
  a_all_off: assert property (p_all_off)
    else $error("word queued with every lane masked");

  property p_addr_lo;
    @(posedge clk_sys) disable iff (!rst_n)
    (run && k_rise && r_reg.wr_pend && !(&m_s))
    |=> r_reg.push_w[BW-1 -: MW] == {$past(r_reg.wa), 1'b0};
  endproperty
  a_addr_lo: assert property (p_addr_lo)
    else $error("first word not at latched address");

  property p_addr_hi;
    @(posedge clk_sys) disable iff (!rst_n)
    (run && kn_rise && r_reg.neg_pend && !(&m_s) && !k_rise)
    |=> (r_reg.push_w[BW-1 -: MW] == {$past(r_reg.wa_hi), 1'b1}
         && r_reg.push_w[NL-1:0] == ~$past(m_s));
  endproperty
  a_addr_hi: assert property (p_addr_hi)
    else $error("second word address or lanes wrong");

  property p_second_slot;
    @(posedge clk_sys) disable iff (!rst_n)
    (run && k_rise && r_reg.wr_pend)
    |=> (r_reg.neg_pend && r_reg.wa_hi == $past(r_reg.wa));
  endproperty
  a_second_slot: assert property (p_second_slot)
    else $error("second data slot not armed");

  property p_oe_start;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(r_reg.oe) |-> ($past(r_reg.stage) == OUT_W0 && $past(out_neg));
  endproperty
  a_oe_start: assert property (p_oe_start)
    else $error("outputs enabled without a read word");

  property p_out_clk;
    @(posedge clk_sys) disable iff (!rst_n)
    $changed(r_reg.q) |-> $past(out_neg || out_pos);
  endproperty
  a_out_clk: assert property (p_out_clk)
    else $error("read data changed off an output edge");

  property p_merge;
    @(posedge clk_sys) disable iff (!rst_n)
    mem_we |-> (b_w[NL-1:0] != '0 && !mem_re);
  endproperty
  a_merge: assert property (p_merge)
    else $error("array written with no lane or during read");

  property p_strap;
    @(posedge clk_sys) disable iff (!rst_n)
    (r_reg.boot == BOOT_DONE) |=> $stable(r_reg.single);
  endproperty
  a_strap: assert property (p_strap)
    else $error("clock mode changed during operation");

endmodule : ddrsm_write_path

`default_nettype wire

//--- ddrsm_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none

module ddrsm_ctrl_model #(
  parameter int ORG = 36,
  parameter int AW  = 6
) (
  input  wire logic                                clk_sys,
  output var  logic                                k_clk,
  output var  logic                                k_clk_n,
  output var  logic                                c_clk,
  output var  logic                                c_clk_n,
  output var  logic                                load_strobe_n,
  output var  logic                                rw_n,
  output var  logic [AW-1:0]                       addr,
  output var  logic [ORG-1:0]                      d_in,
  output var  logic [ddrsm_pkg::lane_cnt(ORG)-1:0] lane_write_mask_n,
  input  wire logic [ORG-1:0]                      q_out,
  input  wire logic                                q_oe
);
  import ddrsm_pkg::*;

  localparam int NL = lane_cnt(ORG);

  logic [ORG-1:0] q_mid;
  logic           oe_mid;
  logic           c_hold = 1'b0;

  initial begin
    k_clk             = 1'b0;
    k_clk_n           = 1'b1;
    c_clk             = 1'b0;
    c_clk_n           = 1'b1;
    load_strobe_n     = 1'b1;
    rw_n              = 1'b1;
    addr              = '0;
    d_in              = '0;
    lane_write_mask_n = '1;
  end

  // ****************************************
  // One pin clock phase, six system cycles
  // ****************************************
  task automatic tick(input logic kv);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    q_mid  = q_out;
    oe_mid = q_oe;
    @(posedge clk_sys);
    k_clk   <= kv;
    k_clk_n <= ~kv;
    c_clk   <= kv | c_hold;
    c_clk_n <= ~kv | c_hold;
    repeat (3) @(posedge clk_sys);
  endtask : tick

  task automatic write_burst(input logic [AW-1:0] a, input logic [ORG-1:0] d0,
                             input logic [NL-1:0] m0, input logic [ORG-1:0] d1,
                             input logic [NL-1:0] m1);
    addr          <= a;
    load_strobe_n <= 1'b0;
    rw_n          <= 1'b0;
    tick(1'b1);
    load_strobe_n <= 1'b1;
    addr          <= ~a;
    tick(1'b0);
    d_in              <= d0;
    lane_write_mask_n <= m0;
    tick(1'b1);
    d_in              <= d1;
    lane_write_mask_n <= m1;
    tick(1'b0);
    d_in <= ~d1;
  endtask : write_burst

  task automatic read_burst(input logic [AW-1:0] a, output logic [ORG-1:0] q0,
                            output logic [ORG-1:0] q1, output logic oe1,
                            output logic oe0);
    addr          <= a;
    load_strobe_n <= 1'b0;
    rw_n          <= 1'b1;
    tick(1'b1);
    load_strobe_n <= 1'b1;
    addr          <= ~a;
    tick(1'b0);
    tick(1'b1);
    tick(1'b0);
    tick(1'b1);
    q0  = q_mid;
    oe1 = oe_mid;
    tick(1'b0);
    q1 = q_mid;
    tick(1'b1);
    tick(1'b0);
    oe0 = oe_mid;
  endtask : read_burst

  // Parked clocks: input pair equal, output pair high from here on
  task automatic park_clocks();
    k_clk   <= 1'b1;
    k_clk_n <= 1'b1;
    c_clk   <= 1'b1;
    c_clk_n <= 1'b1;
    c_hold  = 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask : park_clocks

  task automatic resume_clocks();
    k_clk <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask : resume_clocks
endmodule : ddrsm_ctrl_model

`default_nettype wire

//--- ddrsm_write_path_test.sv
`timescale 1ns/10ps
`default_nettype none

module ddrsm_write_path_test;
  import ddrsm_pkg::*;

  localparam int ORG = ORG_X36;
  localparam int AW  = 6;
  localparam int NL  = 4;

  logic           clk_sys;
  logic           rst_n;
  logic           k_clk;
  logic           k_clk_n;
  logic           c_clk;
  logic           c_clk_n;
  logic           load_strobe_n;
  logic           rw_n;
  logic [AW-1:0]  addr;
  logic [ORG-1:0] d_in;
  logic [NL-1:0]  lane_write_mask_n;
  logic [ORG-1:0] q_out;
  logic           q_oe;
  logic           wr_ready;
  logic           single_clk_mode;
  logic [ORG-1:0] exp_mem [2**AW][2];
  int             mismatches = 0;
  int             cmp_count  = 0;
  int             cycles     = 0;

  ddrsm_write_path #(.ORG(ORG), .ADDR_W(AW)) ddrsm_write_path_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .k_clk(k_clk), .k_clk_n(k_clk_n),
    .c_clk(c_clk), .c_clk_n(c_clk_n), .load_strobe_n(load_strobe_n),
    .rw_n(rw_n), .addr(addr), .d_in(d_in),
    .lane_write_mask_n(lane_write_mask_n), .q_out(q_out), .q_oe(q_oe),
    .wr_ready(wr_ready), .single_clk_mode(single_clk_mode)
  );

  ddrsm_ctrl_model #(.ORG(ORG), .AW(AW)) ddrsm_ctrl_model_inst (
    .clk_sys(clk_sys), .k_clk(k_clk), .k_clk_n(k_clk_n), .c_clk(c_clk),
    .c_clk_n(c_clk_n), .load_strobe_n(load_strobe_n), .rw_n(rw_n),
    .addr(addr), .d_in(d_in), .lane_write_mask_n(lane_write_mask_n),
    .q_out(q_out), .q_oe(q_oe)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [ORG-1:0] e,
                       input logic [ORG-1:0] s);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask : check

  function automatic logic [ORG-1:0] merge(input logic [ORG-1:0] old,
                                           input logic [ORG-1:0] nw,
                                           input logic [NL-1:0]  m);
    merge = old;
    for (int l = 0; l < NL; l++) begin
      if (!m[l]) merge[l*9 +: 9] = nw[l*9 +: 9];
    end
  endfunction : merge

  task automatic wr(input logic [AW-1:0] a, input logic [ORG-1:0] d0,
                    input logic [NL-1:0] m0, input logic [ORG-1:0] d1,
                    input logic [NL-1:0] m1);
    ddrsm_ctrl_model_inst.write_burst(a, d0, m0, d1, m1);
    exp_mem[a][0] = merge(exp_mem[a][0], d0, m0);
    exp_mem[a][1] = merge(exp_mem[a][1], d1, m1);
  endtask : wr

  task automatic rd(input logic [AW-1:0] a);
    logic [ORG-1:0] q0;
    logic [ORG-1:0] q1;
    logic           oe1;
    logic           oe0;
    ddrsm_ctrl_model_inst.read_burst(a, q0, q1, oe1, oe0);
    check("word 0", exp_mem[a][0], q0);
    check("word 1", exp_mem[a][1], q1);
    check("q_oe in burst", 1'b1, oe1);
    check("q_oe after burst", 1'b0, oe0);
  endtask : rd

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset();
    @(negedge clk_sys);
    check("q_oe", 1'b0, q_oe);
    check("single_clk_mode", 1'b0, single_clk_mode);
    check("wr_ready", 1'b1, wr_ready);
    @(posedge clk_sys);
    $display("test reset done");
  endtask : test_reset

  task automatic test_single();
    ddrsm_ctrl_model_inst.park_clocks();
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    ddrsm_ctrl_model_inst.resume_clocks();
    @(negedge clk_sys);
    check("single_clk_mode", 1'b1, single_clk_mode);
    check("q_oe", 1'b0, q_oe);
    @(posedge clk_sys);
    wr(6'h07, 36'h9_1234_5678, 4'h0, 36'h2_468a_ce02, 4'h0);
    wr(6'h07, 36'h0_aaaa_5555, 4'h5, 36'hb_bbbb_bbbb, 4'ha);
    rd(6'h07);
    $display("test single done");
  endtask : test_single

  task automatic test_full();
    wr(6'h05, 36'h1_2345_6789, 4'h0, 36'he_dcba_9876, 4'h0);
    wr(6'h06, 36'h0_5a5a_5a5a, 4'h0, 36'hf_0f0f_0f0f, 4'h0);
    rd(6'h05);
    rd(6'h06);
    $display("test full done");
  endtask : test_full

  task automatic test_lanes();
    logic [8:0] lw;
    for (int l = 0; l < NL; l++) begin
      lw = 9'(l) ^ 9'h1_5a;
      wr(6'h05, {4{lw}}, ~(4'h1 << l), ~{4{lw}}, ~(4'h8 >> l));
      rd(6'h05);
    end
    wr(6'h06, 36'h3_3333_3333, 4'h6, 36'hc_cccc_cccc, 4'h9);
    rd(6'h06);
    $display("test lanes done");
  endtask : test_lanes

  task automatic test_none();
    wr(6'h06, 36'h0_0000_0000, 4'hf, 36'hf_ffff_ffff, 4'hf);
    rd(6'h06);
    wr(6'h05, 36'h7_7777_7777, 4'hf, 36'h8_8888_8888, 4'h0);
    rd(6'h05);
    $display("test none done");
  endtask : test_none

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    test_reset();
    test_full();
    test_lanes();
    test_none();
    test_single();
    stop_test();
  end
endmodule : ddrsm_write_path_test

`default_nettype wire
